// ---- rtl/hta_arbiter.sv ----
`timescale 1ns/1ps
`include "hta_regs.svh"
module hta_arbiter #(
    parameter int PKT_BYTES = `HTA_PKT_BYTES,
    parameter int FIFO_DEPTH = 4,
    parameter logic [31:0] TIMEOUT_CYCLES = `HTA_TIMEOUT_CYC,
    parameter logic [31:0] LOCK_CYCLES = `HTA_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic msg_valid,
    output logic [7:0] msg_data,
    output logic msg_last,
    input wire logic msg_ready,
    output logic msg_start,
    output hta_pkg::hta_hdr_t msg_hdr,
    output logic cancel,
    input wire logic resp_done,
    output logic ctl_valid,
    output hta_pkg::hta_ctl_t ctl,
    input wire logic ctl_ready,
    output logic busy,
    output logic locked,
    input wire logic [5:0] desc_addr,
    output logic [7:0] desc_data
);
    hta_pkg::hta_state_t st_q, st_d;
    logic [6:0] idx_q;
    logic [31:0] cid_q, act_q, act_d, lock_cid_q, lock_cid_d;
    logic [7:0] cmd_q, lenh_q;
    logic [15:0] rem_q, rem_d;
    logic [6:0] seq_q, seq_d;
    logic [31:0] tmr_q, tmr_d, ltmr_q, ltmr_d;
    logic fwd_q, fwd_d, lock_q, lock_d;
    logic ctl_set, flush, start_d, cancel_d;
    hta_pkg::hta_ctl_t ctl_n;
    hta_pkg::hta_hdr_t hdr_d;

    function automatic hta_pkg::hta_ctl_t mk_err(input logic [31:0] c, input logic [7:0] code);
        mk_err = '{channel_identifier: c, cmd: `HTA_CMD_ERROR, len: 8'h01, data: {24'h0, code}};
    endfunction

    wire fire = rx_valid & rx_ready;
    wire pkt_end = fire & (rx_last | (idx_q == 7'(PKT_BYTES - 1)));
    wire at_cmd = fire && idx_q == 7'(`HTA_OFS_CMD);
    wire at_len = fire && idx_q == 7'(`HTA_OFS_LENL);
    wire cont_dec = at_cmd & ~rx_data[`HTA_INIT_BIT];
    wire init_dec = at_len & cmd_q[`HTA_INIT_BIT];
    wire [15:0] len_w = {lenh_q, rx_data};
    wire own = cid_q == act_q;
    wire seq_ok = rx_data[6:0] == seq_q;
    wire push = fire & fwd_q & (rem_q != 16'h0);
    wire foreign_lock = lock_q & (lock_cid_q != cid_q);
    wire tmo = st_q == hta_pkg::S_RECV && tmr_q == 32'h0;
    wire is_msg = cmd_q == `HTA_CMD_MSG || cmd_q == `HTA_CMD_CBOR;
    wire idle = st_q == hta_pkg::S_IDLE;

    always_comb begin
        st_d = st_q;
        act_d = act_q;
        rem_d = rem_q;
        seq_d = seq_q;
        fwd_d = fwd_q;
        tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
        lock_d = lock_q & (ltmr_q != 32'h0);
        ltmr_d = (ltmr_q != 32'h0) ? ltmr_q - 32'h1 : ltmr_q;
        lock_cid_d = lock_cid_q;
        ctl_set = 1'b0;
        ctl_n = '0;
        flush = 1'b0;
        start_d = 1'b0;
        cancel_d = 1'b0;
        hdr_d = msg_hdr;
        if (push) begin
            rem_d = rem_q - 16'h1;
            if (rem_q == 16'h1) st_d = hta_pkg::S_PROC;
        end
        if (pkt_end) fwd_d = 1'b0;
        // processing stays open until resp_done or a channel init from the active channel, so keep-alives sent meanwhile do not end it
        if (st_q == hta_pkg::S_PROC && resp_done) st_d = hta_pkg::S_IDLE;
        if (tmo) begin
            st_d = hta_pkg::S_IDLE;
            flush = 1'b1;
            fwd_d = 1'b0;
            ctl_set = 1'b1;
            ctl_n = mk_err(act_q, `HTA_ERR_TIMEOUT);
        end else if (cont_dec && st_q == hta_pkg::S_RECV && own) begin
            if (seq_ok) begin
                fwd_d = 1'b1;
                seq_d = (seq_q == `HTA_SEQ_MAX) ? 7'h0 : seq_q + 7'h1;
                tmr_d = TIMEOUT_CYCLES;
            end else begin
                st_d = hta_pkg::S_IDLE;
                flush = 1'b1;
                ctl_set = 1'b1;
                ctl_n = mk_err(cid_q, `HTA_ERR_SEQ);
            end
        end else if (init_dec) begin
            if (!idle && own && cmd_q == `HTA_CMD_INIT) begin
                st_d = hta_pkg::S_IDLE;
                flush = 1'b1;
                fwd_d = 1'b0;
                ctl_set = 1'b1;
                ctl_n = '{channel_identifier: cid_q, cmd: `HTA_CMD_INIT, len: 8'h04, data: cid_q};
            end else if (!idle && own && cmd_q == `HTA_CMD_CANCEL) begin
                cancel_d = st_q == hta_pkg::S_PROC;
            end else if (st_q == hta_pkg::S_RECV && own) begin
                st_d = hta_pkg::S_IDLE;
                flush = 1'b1;
                fwd_d = 1'b0;
                ctl_set = 1'b1;
                ctl_n = mk_err(cid_q, `HTA_ERR_SEQ);
            end else if (!idle || foreign_lock) begin
                ctl_set = 1'b1;
                ctl_n = mk_err(cid_q, `HTA_ERR_BUSY);
            end else if (cmd_q == `HTA_CMD_CANCEL) begin
                ctl_set = 1'b0;
            end else if (cmd_q == `HTA_CMD_LOCK) begin
                lock_d = len_w != 16'h0;
                ltmr_d = LOCK_CYCLES;
                lock_cid_d = cid_q;
                ctl_set = 1'b1;
                ctl_n = '{channel_identifier: cid_q, cmd: `HTA_CMD_LOCK, len: 8'h00, data: 32'h0};
            end else if (is_msg && len_w == 16'h0) begin
                ctl_set = 1'b1;
                ctl_n = mk_err(cid_q, `HTA_ERR_LEN);
            end else begin
                act_d = cid_q;
                hdr_d = '{channel_identifier: cid_q, cmd: cmd_q, len: len_w};
                start_d = 1'b1;
                rem_d = len_w;
                seq_d = 7'h0;
                fwd_d = len_w != 16'h0;
                tmr_d = TIMEOUT_CYCLES;
                st_d = (len_w != 16'h0) ? hta_pkg::S_RECV : hta_pkg::S_PROC;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) idx_q <= 7'h0;
        else if (pkt_end) idx_q <= 7'h0;
        else if (fire) idx_q <= idx_q + 7'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cid_q <= 32'h0;
            cmd_q <= 8'h0;
            lenh_q <= 8'h0;
        end else if (fire) begin
            if (idx_q < 7'(`HTA_OFS_CMD)) cid_q <= {cid_q[23:0], rx_data};
            if (idx_q == 7'(`HTA_OFS_CMD)) cmd_q <= rx_data;
            if (idx_q == 7'(`HTA_OFS_LENH)) lenh_q <= rx_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= hta_pkg::S_IDLE;
            act_q <= 32'h0;
            rem_q <= 16'h0;
            seq_q <= 7'h0;
            fwd_q <= 1'b0;
            tmr_q <= 32'h0;
        end else begin
            st_q <= st_d;
            act_q <= act_d;
            rem_q <= rem_d;
            seq_q <= seq_d;
            fwd_q <= fwd_d;
            tmr_q <= tmr_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q <= 1'b0;
            ltmr_q <= 32'h0;
            lock_cid_q <= 32'h0;
        end else begin
            lock_q <= lock_d;
            ltmr_q <= ltmr_d;
            lock_cid_q <= lock_cid_d;
        end
    end

    // a new control message wins over the handshake that retires the old one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_valid <= 1'b0;
            ctl <= '0;
        end else if (ctl_set && (!ctl_valid || ctl_ready)) begin
            ctl_valid <= 1'b1;
            ctl <= ctl_n;
        end else if (ctl_ready) begin
            ctl_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msg_start <= 1'b0;
            msg_hdr <= '0;
            cancel <= 1'b0;
            busy <= 1'b0;
            locked <= 1'b0;
        end else begin
            msg_start <= start_d;
            msg_hdr <= hdr_d;
            cancel <= cancel_d;
            busy <= st_d != hta_pkg::S_IDLE;
            locked <= lock_d;
        end
    end

    hta_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush),
        .in_valid(push),
        .in_data({rem_q == 16'h1, rx_data}),
        .in_ready(rx_ready),
        .out_valid(msg_valid),
        .out_data({msg_last, msg_data}),
        .out_ready(msg_ready)
    );

    hta_desc_rom #(
        .USAGE_PAGE(16'hff5a),
        .PKT_BYTES(8'(PKT_BYTES))
    ) u_rom (
        .clk(clk),
        .rst(rst),
        .addr(desc_addr),
        .data(desc_data)
    );
endmodule // hta_arbiter

// ---- include/hta_regs.svh ----
`ifndef HTA_REGS_SVH
`define HTA_REGS_SVH
// Function
// - idle arbiter locks to first channel opening a request, until response done or abort
// - init packet from another channel while busy gets an immediate busy error
// - unfinished transaction times out, pending request dropped, arbiter back to idle
// - channel init on the active channel aborts, flushes buffered data, returns idle
// - continuation sequence checked ascending without gaps; assembly runs until complete or timeout
// - continuation packet without an opened transaction is silently ignored
// - optional channel lock blocks other channels until lock expires or is released
// - one IN and one OUT endpoint besides control; 64-byte packets by default
// - interface descriptor: two endpoints, HID class, no subclass, no protocol
// - interrupt endpoints, 5 ms interval, OUT address 0x01, IN address 0x81
// - report descriptor: one raw input and one raw output report, 8-bit elements
// - discovery uses a 16-bit vendor usage page with usage value 0x01
// - legacy message: command byte plus n bytes; response status plus n bytes
// - structured message, code 0x10: command byte plus n encoded bytes, same response
// - device may send keep-alives to requester before the final structured response
// - init packet has command bit 7 set; continuation sequence 0 to 127, bit 7 clear
// - busy rejection is an error response with code 0x06
// - channel init on allocated channel discards transaction, replies with its identifier

`define HTA_CLK_KHZ 200000
`define HTA_TIMEOUT_MS 500
`define HTA_LOCK_MS 3000
`define HTA_TIMEOUT_CYC (`HTA_TIMEOUT_MS * `HTA_CLK_KHZ)
`define HTA_LOCK_CYC (`HTA_LOCK_MS * `HTA_CLK_KHZ)

`define HTA_PKT_BYTES 64
`define HTA_OFS_CMD 4
`define HTA_OFS_LENH 5
`define HTA_OFS_LENL 6
`define HTA_INIT_BIT 7
`define HTA_SEQ_MAX 7'h7f

`define HTA_CMD_MSG 8'h83
`define HTA_CMD_LOCK 8'h84
`define HTA_CMD_INIT 8'h86
`define HTA_CMD_CBOR 8'h90
`define HTA_CMD_CANCEL 8'h91
`define HTA_CMD_ERROR 8'hbf

`define HTA_ERR_LEN 8'h03
`define HTA_ERR_SEQ 8'h04
`define HTA_ERR_TIMEOUT 8'h05
`define HTA_ERR_BUSY 8'h06

`define HTA_DESC_IF_CLASS 8'h03
`define HTA_DESC_IF_SUB 8'h00
`define HTA_DESC_IF_PROTO 8'h00
`define HTA_DESC_NUM_EP 8'h02
`define HTA_DESC_EP_ATTR 8'h03
`define HTA_DESC_EP_OUT 8'h01
`define HTA_DESC_EP_IN 8'h81
`define HTA_DESC_INTERVAL 8'h05
`define HTA_DESC_USAGE 8'h01
`define HTA_DESC_ELEM_BITS 8'h08
`define HTA_DESC_BYTES 57
`endif

// ---- include/hta_pkg.sv ----
package hta_pkg;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RECV = 2'b01,
        S_PROC = 2'b10
    } hta_state_t;

    typedef struct packed {
        logic [31:0] channel_identifier;
        logic [7:0] cmd;
        logic [15:0] len;
    } hta_hdr_t;

    typedef struct packed {
        logic [31:0] channel_identifier;
        logic [7:0] cmd;
        logic [7:0] len;
        logic [31:0] data;
    } hta_ctl_t;
endpackage

// ---- rtl/hta_fifo.sv ----
`timescale 1ns/1ps
module hta_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) wr_q <= inc(wr_q);
            if (pop) rd_q <= inc(rd_q);
            cnt_q <= cnt_d;
            in_ready <= cnt_d != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q] <= in_data;
    end
endmodule // hta_fifo

// ---- rtl/hta_desc_rom.sv ----
`timescale 1ns/1ps
`include "hta_regs.svh"
module hta_desc_rom #(
    // usage page value is arbitrary, vendor range
    parameter logic [15:0] USAGE_PAGE = 16'hff5a,
    parameter logic [7:0] PKT_BYTES = 8'h40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] addr,
    output logic [7:0] data
);
    // interface, out endpoint, in endpoint, then report descriptor
    function automatic logic [7:0] rom(input logic [5:0] a);
        case (a)
            6'h00: rom = 8'h09;
            6'h01: rom = 8'h04;
            6'h04: rom = `HTA_DESC_NUM_EP;
            6'h05: rom = `HTA_DESC_IF_CLASS;
            6'h06: rom = `HTA_DESC_IF_SUB;
            6'h07: rom = `HTA_DESC_IF_PROTO;
            6'h09, 6'h10: rom = 8'h07;
            6'h0a, 6'h11: rom = 8'h05;
            6'h0b: rom = `HTA_DESC_EP_OUT;
            6'h12: rom = `HTA_DESC_EP_IN;
            6'h0c, 6'h13: rom = `HTA_DESC_EP_ATTR;
            6'h0d, 6'h14: rom = PKT_BYTES;
            6'h0f, 6'h16: rom = `HTA_DESC_INTERVAL;
            6'h17: rom = 8'h06;
            6'h18: rom = USAGE_PAGE[7:0];
            6'h19: rom = USAGE_PAGE[15:8];
            6'h1a: rom = 8'h09;
            6'h1b: rom = `HTA_DESC_USAGE;
            6'h1c: rom = 8'ha1;
            6'h1d: rom = 8'h01;
            6'h1e, 6'h28: rom = 8'h09;
            6'h1f: rom = 8'h20;
            6'h29: rom = 8'h21;
            6'h20, 6'h2a: rom = 8'h15;
            6'h22, 6'h2c: rom = 8'h26;
            6'h23, 6'h2d: rom = 8'hff;
            6'h25, 6'h2f: rom = 8'h75;
            6'h26, 6'h30: rom = `HTA_DESC_ELEM_BITS;
            6'h27, 6'h31: rom = 8'h95;
            6'h32: rom = PKT_BYTES;
            6'h33: rom = 8'h91;
            6'h34: rom = 8'h02;
            6'h35: rom = 8'hc0;
            default: rom = 8'h00;
        endcase
    endfunction

    // input report items sit between the two usage blocks
    wire [5:0] fix = (addr == 6'h28) ? 6'h27 : addr;
    wire [7:0] rd = (addr == 6'h28) ? PKT_BYTES
                  : (addr == 6'h29) ? 8'h81
                  : (addr == 6'h2a) ? 8'h02
                  : (addr >= 6'h2b && addr < 6'h39) ? rom(addr - 6'h02)
                  : rom(fix);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) data <= 8'h00;
        else data <= rd;
    end
endmodule // hta_desc_rom

// ---- verif/hta_arbiter_monitor.sv ----
`timescale 1ns/1ps
module hta_arbiter_monitor #(
    parameter logic [31:0] LOCK_CYCLES = 32'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic msg_valid,
    input wire logic [7:0] msg_data,
    input wire logic msg_ready,
    input wire logic msg_start,
    input wire hta_pkg::hta_hdr_t msg_hdr,
    input wire logic ctl_valid,
    input wire hta_pkg::hta_ctl_t ctl,
    input wire logic ctl_ready,
    input wire logic busy,
    input wire logic locked,
    input wire logic [5:0] desc_addr,
    input wire logic [7:0] desc_data
);
    logic [31:0] lock_cnt_q;
    logic [5:0] addr_q;
    logic [8:0] dexp;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    function automatic logic [8:0] desc_exp(input logic [5:0] a);
        case (a)
            6'h04: return 9'h102;
            6'h05: return 9'h103;
            6'h06, 6'h07: return 9'h100;
            6'h0b: return 9'h101;
            6'h12: return 9'h181;
            6'h0c, 6'h13: return 9'h103;
            6'h0f, 6'h16: return 9'h105;
            default: return 9'h000;
        endcase
    endfunction
    assign dexp = desc_exp(addr_q);
    // lock age restarts with every lock reply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_q <= 32'h0;
            addr_q <= 6'h00;
        end else begin
            addr_q <= desc_addr;
            if (!locked || (ctl_valid && ctl.cmd == 8'h84)) begin
                lock_cnt_q <= 32'h0;
            end else begin
                lock_cnt_q <= lock_cnt_q + 32'h1;
            end
        end
    end
    sequence s_ctl_wait;
        ctl_valid && !ctl_ready;
    endsequence
    sequence s_msg_wait;
        msg_valid && !msg_ready;
    endsequence
    property p_ctl_hold;
        s_ctl_wait |=> ctl_valid && $stable(ctl);
    endproperty
    property p_msg_hold;
        s_msg_wait |=> msg_valid && $stable(msg_data);
    endproperty
    property p_start;
        msg_start |-> busy && msg_hdr.cmd[7] ##1 !msg_start;
    endproperty
    property p_err_len;
        ctl_valid && ctl.cmd == 8'hbf |-> ctl.len == 8'h01;
    endproperty
    property p_sync;
        ctl_valid && ctl.cmd == 8'h86 |-> ctl.len == 8'h04 && ctl.data == ctl.channel_identifier;
    endproperty
    property p_lock_bound;
        locked |-> lock_cnt_q <= LOCK_CYCLES + 32'h8;
    endproperty
    property p_desc_if;
        dexp[8] && addr_q < 6'h08 |-> desc_data == dexp[7:0];
    endproperty
    property p_desc_ep;
        dexp[8] && addr_q > 6'h08 |-> desc_data == dexp[7:0];
    endproperty
    a_ctl_hold: assert property (p_ctl_hold)
        else $error("control message changed while stalled");
    a_msg_hold: assert property (p_msg_hold)
        else $error("payload byte changed while stalled");
    a_start: assert property (p_start)
        else $error("start pulse malformed");
    a_err_len: assert property (p_err_len)
        else $error("error reply length wrong");
    a_sync: assert property (p_sync)
        else $error("sync reply malformed");
    a_lock_bound: assert property (p_lock_bound)
        else $error("lock held too long");
    a_desc_if: assert property (p_desc_if)
        else $error("interface descriptor byte wrong");
    a_desc_ep: assert property (p_desc_ep)
        else $error("endpoint descriptor byte wrong");
endmodule // hta_arbiter_monitor
bind hta_arbiter hta_arbiter_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) i_mon (.clk(clk), .rst(rst), .msg_valid(msg_valid),
    .msg_data(msg_data), .msg_ready(msg_ready), .msg_start(msg_start), .msg_hdr(msg_hdr), .ctl_valid(ctl_valid),
    .ctl(ctl), .ctl_ready(ctl_ready), .busy(busy), .locked(locked), .desc_addr(desc_addr), .desc_data(desc_data));

// ---- verif/hta_app_model.sv ----
`timescale 1ns/1ps
module hta_app_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic msg_valid,
    input wire logic [7:0] msg_data,
    input wire logic msg_last,
    output logic msg_ready,
    input wire logic ctl_valid,
    input wire hta_pkg::hta_ctl_t ctl,
    output logic ctl_ready
);
    logic [8:0] got_q[$];
    hta_pkg::hta_ctl_t ctl_q[$];
    initial begin
        msg_ready = 1'b0;
        ctl_ready = 1'b0;
    end
    // random stalls on both sides, full stall of msg_ready only while hold
    always @(negedge clk) begin
        msg_ready <= !hold && ($urandom % 4 != 0);
        ctl_ready <= ($urandom % 4 != 0);
    end
    always @(posedge clk) begin
        if (!rst && msg_valid && msg_ready) got_q.push_back({msg_last, msg_data});
        if (!rst && ctl_valid && ctl_ready) ctl_q.push_back(ctl);
    end
endmodule // hta_app_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    localparam int PB = 16;
    logic clk, rst, rx_valid, rx_last, rx_ready, msg_valid, msg_last, msg_ready, msg_start, cancel;
    logic resp_done, ctl_valid, ctl_ready, busy, locked, hold;
    logic [7:0] rx_data, msg_data, desc_data;
    logic [5:0] desc_addr;
    logic [31:0] channel_identifier, oth;
    logic [7:0] cmd;
    hta_pkg::hta_hdr_t msg_hdr;
    hta_pkg::hta_ctl_t ctl, c;
    int errors, comparisons, cancels, rem, len;
    logic [8:0] exp_q[$];
    logic [13:0] dt[10] = '{14'h0402, 14'h0503, 14'h0600, 14'h0700, 14'h0b01, 14'h0c03, 14'h0f05, 14'h1281,
        14'h1303, 14'h1605};
    hta_arbiter #(.PKT_BYTES(PB), .FIFO_DEPTH(4), .TIMEOUT_CYCLES(32'd200), .LOCK_CYCLES(32'd300)) i_dut (
        .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
        .msg_valid(msg_valid), .msg_data(msg_data), .msg_last(msg_last), .msg_ready(msg_ready),
        .msg_start(msg_start), .msg_hdr(msg_hdr), .cancel(cancel), .resp_done(resp_done),
        .ctl_valid(ctl_valid), .ctl(ctl), .ctl_ready(ctl_ready), .busy(busy), .locked(locked),
        .desc_addr(desc_addr), .desc_data(desc_data));
    hta_app_model i_app (.clk(clk), .rst(rst), .hold(hold), .msg_valid(msg_valid), .msg_data(msg_data),
        .msg_last(msg_last), .msg_ready(msg_ready), .ctl_valid(ctl_valid), .ctl(ctl), .ctl_ready(ctl_ready));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (cancel === 1'b1) cancels++;
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic l);
        int n;
        n = 0;
        rx_valid = 1'b1;
        rx_data = b;
        rx_last = l;
        while (rx_ready !== 1'b1 && n < 200) begin
            n++;
            @(negedge clk);
        end
        @(negedge clk);
    endtask
    // one whole report; kept payload bytes become expected output
    task automatic pkt(input logic [31:0] id, input logic [7:0] b4, input int n, input bit keep);
        logic [7:0] b;
        if (keep && b4[7]) rem = n;
        for (int i = 0; i < PB; i++) begin
            b = 8'($urandom);
            if (i < 4) b = id[31-8*i -: 8];
            else if (i == 4) b = b4;
            else if (b4[7] && i == 5) b = n[15:8];
            else if (b4[7] && i == 6) b = n[7:0];
            else if (keep && rem > 0) begin
                rem--;
                exp_q.push_back({rem == 0, b});
            end
            put(b, i == PB - 1);
        end
        rx_valid = 1'b0;
    endtask
    task automatic expect_ctl(input logic [31:0] id, input logic [7:0] k, input logic [7:0] l, input logic [7:0] d);
        int n;
        n = 0;
        while (i_app.ctl_q.size() == 0 && n < 400) begin
            n++;
            @(negedge clk);
        end
        c = (i_app.ctl_q.size() != 0) ? i_app.ctl_q.pop_front() : 'x;
        check({c.channel_identifier, c.cmd, c.len, (l == 8'h00) ? 8'h00 : c.data[7:0]}, {id, k, l, d});
    endtask
    task automatic new_test;
        rem = 0;
        exp_q.delete();
        repeat (20) @(negedge clk);
        i_app.got_q.delete();
        i_app.ctl_q.delete();
        channel_identifier = {8'h10, 24'($urandom)};
        oth = channel_identifier ^ 32'h0100_0000;
    endtask
    task automatic complete_run;
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(5ns * 30000);
        errors++;
        complete_run();
    end
    initial begin
        {rx_valid, rx_data, rx_last, resp_done, desc_addr, hold} = '0;
        {errors, comparisons, cancels} = '0;
        rst = 1'b1;
        void'($urandom(32'h2d9acf33));
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (dt[i]) begin
            desc_addr = dt[i][13:8];
            repeat (2) @(negedge clk);
            check(desc_data, dt[i][7:0]);
        end
        $display("test descriptors done");
        for (int k = 0; k < 6; k++) begin
            new_test();
            cmd = (k % 2) ? 8'h83 : 8'h90;
            len = (k == 0) ? 9 : 1 + $urandom % 40;
            hold = (k == 0);
            fork
                pkt(channel_identifier, cmd, len, 1);
                if (k == 0) begin
                    repeat (30) @(negedge clk);
                    check(rx_ready, 1'b0);
                    hold = 1'b0;
                end
            join
            check(busy, 1'b1);
            pkt(oth, 8'h90, 1, 0);
            expect_ctl(oth, 8'hbf, 8'h01, 8'h06);
            pkt(oth, 8'h00, 0, 0);
            for (int s = 0; rem > 0; s++) pkt(channel_identifier, 8'(s), 0, 1);
            for (int n = 0; i_app.got_q.size() < exp_q.size() && n < 300; n++) @(negedge clk);
            check(i_app.got_q.size(), exp_q.size());
            foreach (exp_q[i]) check(i_app.got_q[i], exp_q[i]);
            check(msg_hdr, {channel_identifier, cmd, 16'(len)});
            pkt(channel_identifier, 8'h91, 0, 0);
            repeat (4) @(negedge clk);
            check(cancels, k + 1);
            resp_done = 1'b1;
            @(negedge clk);
            resp_done = 1'b0;
            @(negedge clk);
            check(busy, 1'b0);
            $display("test transaction %0d done", k);
        end
        new_test();
        pkt(channel_identifier, 8'h00, 0, 0);
        repeat (20) @(negedge clk);
        check({busy, 8'(i_app.ctl_q.size()), 8'(i_app.got_q.size())}, 17'h0);
        $display("test spurious continuation done");
        new_test();
        pkt(channel_identifier, 8'h90, 30, 0);
        pkt(channel_identifier, 8'h01, 0, 0);
        expect_ctl(channel_identifier, 8'hbf, 8'h01, 8'h04);
        check(busy, 1'b0);
        new_test();
        pkt(channel_identifier, 8'h90, 30, 0);
        pkt(channel_identifier, 8'h86, 8, 0);
        expect_ctl(channel_identifier, 8'h86, 8'h04, channel_identifier[7:0]);
        check(busy, 1'b0);
        $display("test sequence error and abort done");
        new_test();
        pkt(channel_identifier, 8'h90, 30, 0);
        repeat (150) @(negedge clk);
        pkt(channel_identifier, 8'h00, 0, 0);
        repeat (150) @(negedge clk);
        check(busy, 1'b1);
        expect_ctl(channel_identifier, 8'hbf, 8'h01, 8'h05);
        check(busy, 1'b0);
        $display("test timeout done");
        new_test();
        pkt(channel_identifier, 8'h84, 1, 0);
        expect_ctl(channel_identifier, 8'h84, 8'h00, 8'h00);
        check(locked, 1'b1);
        pkt(oth, 8'h90, 1, 0);
        expect_ctl(oth, 8'hbf, 8'h01, 8'h06);
        pkt(channel_identifier, 8'h84, 0, 0);
        expect_ctl(channel_identifier, 8'h84, 8'h00, 8'h00);
        check(locked, 1'b0);
        pkt(channel_identifier, 8'h84, 1, 0);
        repeat (330) @(negedge clk);
        check(locked, 1'b0);
        $display("test channel lock done");
        complete_run();
    end
endmodule // tb_top
